// File: verilog/hardware_configuration_regs.vh
// register map, field positions, reset values and timing counts of the hardware configuration block
`ifndef HARDWARE_CONFIGURATION_REGS_VH
`define HARDWARE_CONFIGURATION_REGS_VH

// ==========================================================
// register byte offsets
`define HWCFG_OFFSET 12'h074
`define INT_STS_OFFSET 12'h080
`define INT_EN_OFFSET 12'h084
`define INT_CLR_OFFSET 12'h088

// ==========================================================
// hardware_configuration fields
`define HWCFG_SOFT_RESET_REQUEST_BIT 0
`define HWCFG_TIMEOUT_BIT 1
`define HWCFG_EXT_EN_BIT 2
`define HWCFG_DETECT_BIT 3
`define HWCFG_MGMT_SEL_BIT 4
`define HWCFG_CLKSEL_LSB 5
`define HWCFG_CLKSEL_MSB 6
`define HWCFG_CLKSEL_RESET 2'h0
`define HWCFG_EXT_EN_RESET 1'h0
`define HWCFG_MGMT_SEL_RESET 1'h0

// mii clock source codes
`define CLKSEL_INTERNAL_A 2'h0
`define CLKSEL_EXTERNAL 2'h1
`define CLKSEL_DISABLED 2'h2
`define CLKSEL_INTERNAL_B 2'h3

// ==========================================================
// interrupt status, enable and clear layout
`define INT_WIDTH 4
`define INT_SOFT_RESET_REQUEST_DONE_BIT 0
`define INT_SOFT_RESET_REQUEST_TIMEOUT_BIT 1
`define INT_TX_ERROR_BIT 2
`define INT_RX_ERROR_BIT 3
`define INT_EN_RESET 4'h0

// ==========================================================
// timing
`define CLK_PERIOD_PS 32'h00000FA0
// 10 us soft reset timeout
`define SOFT_RESET_REQUEST_TIMEOUT_NS 32'h00002710
`define SOFT_RESET_REQUEST_TIMEOUT_CYCLES ((`SOFT_RESET_REQUEST_TIMEOUT_NS * 32'h000003E8) / `CLK_PERIOD_PS)
// 200 ns without an edge means the phy clock is stopped
`define PHY_CLK_IDLE_NS 32'h000000C8
`define PHY_CLK_IDLE_CYCLES ((`PHY_CLK_IDLE_NS * 32'h000003E8) / `CLK_PERIOD_PS)
`define SOFT_RESET_REQUEST_PULSE_CYCLES 4'h4

`endif

// File: verilog/phy_clk_monitor.v
// activity monitor that tells whether a slow phy clock is toggling
`timescale 1ns/1ps
`default_nettype none
`include "hardware_configuration_regs.vh"

module phy_clk_monitor
(
    // system side
    input wire pclk,
    input wire presetn,
    // monitored clock, sampled as data
    input wire sample_clk,
    // result
    output reg running
);

    localparam [31:0] IDLE_FULL = `PHY_CLK_IDLE_CYCLES;
    localparam [7:0] IDLE_LIMIT = IDLE_FULL[7:0];

    reg sync_a;
    reg sync_b;
    reg sync_c;
    reg [7:0] idle_count;

    // ==========================================================
    // two-stage synchroniser, then edge detect on the later stages
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 1'h0;
            sync_b <= 1'h0;
            sync_c <= 1'h0;
            idle_count <= 8'h00;
            running <= 1'h0;
        end
        else
        begin
            sync_a <= sample_clk;
            sync_b <= sync_a;
            sync_c <= sync_b;
            if (sync_b != sync_c)
            begin
                idle_count <= 8'h00;
                running <= 1'h1;
            end
            else if (idle_count == IDLE_LIMIT)
            begin
                running <= 1'h0;
            end
            else
            begin
                idle_count <= idle_count + 8'h01;
            end
        end
    end

endmodule
`default_nettype wire

// File: verilog/hw_config.v
// hardware configuration register: phy port selection, strap detect and soft reset
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hardware_configuration_regs.vh"

// How it works
// - clock select 00/11 internal, 01 external, 10 off
// - clock select touches only rx/tx clocks
// - mgmt select routes all transactions
// - selected external: internal mdio/mdc driven low
// - selected internal: external mdio released, mdc low
// - mgmt select independent of port enable
// - strap latched from external mdio at reset
// - strap value only readable, drives nothing
// - port enable picks external port or internal phy
// - port enable leaves mgmt and clocks alone
// - stopped phy clocks: reset fails, flag set
// - soft reset resets mac and system registers
// - soft reset clears errors, bit self-clears
// - writes ignored until first read
// - clock select at bits 6:5, resets 00
module hw_config
(
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // events and power state
    input wire tx_error_event,
    input wire rx_error_event,
    input wire wake_event,
    // internal phy clocks, sampled for activity only
    input wire int_rx_clk,
    input wire int_tx_clk,
    // mac management master
    input wire mgmt_mdc,
    input wire mgmt_mdio_o,
    input wire mgmt_mdio_oe,
    output wire mgmt_mdio_i,
    // internal phy management lines
    output wire int_mdc,
    output wire int_mdio_o,
    output wire int_mdio_oe,
    input wire int_mdio_i,
    // external phy management pins
    output wire ext_mdc,
    output wire ext_mdio_o,
    output wire ext_mdio_oe,
    input wire ext_mdio_i,
    // mii clock routing and port enables
    output reg clk_route_internal,
    output reg clk_route_external,
    output reg clk_route_disabled,
    output reg external_mii_port_enable,
    output reg internal_phy_enable,
    // soft reset outputs and error flags
    output reg mac_csr_reset,
    output reg system_command_status_reset,
    output reg transmit_error_flag,
    output reg receive_error_flag,
    // interrupt
    output wire irq
);

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_HWCFG = 3'h1;
    localparam [2:0] SEL_STS = 3'h2;
    localparam [2:0] SEL_EN = 3'h3;
    localparam [2:0] SEL_CLR = 3'h4;

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_WAIT_CLK = 2'h1;
    localparam [1:0] S_PULSE = 2'h2;

    localparam [31:0] TIMEOUT_FULL = `SOFT_RESET_REQUEST_TIMEOUT_CYCLES;
    localparam [11:0] TIMEOUT_LIMIT = TIMEOUT_FULL[11:0];

    // ==========================================================
    // helpers
    function [2:0] reg_select;
        input [11:0] addr;
        begin
            if (addr == `HWCFG_OFFSET)
                reg_select = SEL_HWCFG;
            else if (addr == `INT_STS_OFFSET)
                reg_select = SEL_STS;
            else if (addr == `INT_EN_OFFSET)
                reg_select = SEL_EN;
            else if (addr == `INT_CLR_OFFSET)
                reg_select = SEL_CLR;
            else
                reg_select = SEL_NONE;
        end
    endfunction

    reg [1:0] mii_clock_source_select;
    reg mgmt_port_target_select;
    reg external_phy_strap_detect;
    reg soft_reset_timeout_flag;
    reg soft_reset_request;
    reg read_seen;
    reg [1:0] soft_reset_request_state;
    reg [11:0] timeout_count;
    reg [3:0] pulse_count;
    reg soft_reset_request_done_event;
    reg soft_reset_request_timeout_event;
    reg [`INT_WIDTH-1:0] int_status;
    reg [`INT_WIDTH-1:0] int_enable;
    reg [`INT_WIDTH-1:0] next_int_status;
    reg ext_mdio_sync_a;
    reg ext_mdio_sync_b;
    reg [1:0] strap_wait;
    reg strap_taken;
    reg [31:0] next_prdata;
    wire rx_clk_running;
    wire tx_clk_running;
    wire [2:0] setup_sel;
    wire [2:0] access_sel;
    wire access;
    wire wr_en;
    wire rd_done;
    wire soft_reset_request_write;
    wire [`INT_WIDTH-1:0] clr_mask;
    wire [`INT_WIDTH-1:0] set_mask;

    // ==========================================================
    // apb decode
    assign setup_sel = reg_select(paddr);
    assign access_sel = reg_select(paddr);
    assign access = psel & penable;
    assign pready = 1'h1;
    assign pslverr = access & ((access_sel == SEL_NONE) |
                     (pwrite & (access_sel == SEL_STS)) |
                     (~pwrite & (access_sel == SEL_CLR)));
    assign wr_en = access & pwrite & read_seen & pstrb[0];
    assign rd_done = access & ~pwrite;
    assign soft_reset_request_write = wr_en & (access_sel == SEL_HWCFG) & pwdata[`HWCFG_SOFT_RESET_REQUEST_BIT];
    assign clr_mask = (wr_en & (access_sel == SEL_CLR)) ? pwdata[`INT_WIDTH-1:0] : 4'h0;

    // read data is built in the setup phase so it stands through the access phase
    always @*
    begin
        next_prdata = 32'h00000000;
        if (setup_sel == SEL_HWCFG)
        begin
            next_prdata[`HWCFG_CLKSEL_MSB:`HWCFG_CLKSEL_LSB] = mii_clock_source_select;
            next_prdata[`HWCFG_MGMT_SEL_BIT] = mgmt_port_target_select;
            next_prdata[`HWCFG_DETECT_BIT] = external_phy_strap_detect;
            next_prdata[`HWCFG_EXT_EN_BIT] = external_mii_port_enable;
            next_prdata[`HWCFG_TIMEOUT_BIT] = soft_reset_timeout_flag;
            next_prdata[`HWCFG_SOFT_RESET_REQUEST_BIT] = soft_reset_request;
        end
        else if (setup_sel == SEL_STS)
        begin
            next_prdata[`INT_WIDTH-1:0] = int_status;
        end
        else if (setup_sel == SEL_EN)
        begin
            next_prdata[`INT_WIDTH-1:0] = int_enable;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel & ~penable)
            prdata <= next_prdata;
    end

    // ==========================================================
    // first read after reset, soft reset or wake unlocks writes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            read_seen <= 1'h0;
        // relock on soft reset or wake
        else if (wake_event | (soft_reset_request_state == S_PULSE))
            read_seen <= 1'h0;
        else if (rd_done)
            read_seen <= 1'h1;
    end

    // ==========================================================
    // configuration fields
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mii_clock_source_select <= `HWCFG_CLKSEL_RESET;
            mgmt_port_target_select <= `HWCFG_MGMT_SEL_RESET;
            external_mii_port_enable <= `HWCFG_EXT_EN_RESET;
            int_enable <= `INT_EN_RESET;
        end
        else if (wr_en)
        begin
            if (access_sel == SEL_HWCFG)
            begin
                mii_clock_source_select <= pwdata[`HWCFG_CLKSEL_MSB:`HWCFG_CLKSEL_LSB];
                mgmt_port_target_select <= pwdata[`HWCFG_MGMT_SEL_BIT];
                external_mii_port_enable <= pwdata[`HWCFG_EXT_EN_BIT];
            end
            else if (access_sel == SEL_EN)
            begin
                int_enable <= pwdata[`INT_WIDTH-1:0];
            end
        end
    end

    // ==========================================================
    // mii clock routing and port enable
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_route_internal <= 1'h1;
            clk_route_external <= 1'h0;
            clk_route_disabled <= 1'h0;
            internal_phy_enable <= 1'h1;
        end
        else
        begin
            // only rx/tx clock routing follows the select
            clk_route_internal <= (mii_clock_source_select == `CLKSEL_INTERNAL_A) |
                                  (mii_clock_source_select == `CLKSEL_INTERNAL_B);
            clk_route_external <= (mii_clock_source_select == `CLKSEL_EXTERNAL);
            clk_route_disabled <= (mii_clock_source_select == `CLKSEL_DISABLED);
            // internal phy on when external port off
            internal_phy_enable <= ~external_mii_port_enable;
        end
    end

    // ==========================================================
    // management serial port steering
    // route by target select
    assign mgmt_mdio_i = mgmt_port_target_select ? ext_mdio_sync_b : int_mdio_i;
    // internal lines held low when external is chosen
    assign int_mdc = mgmt_port_target_select ? 1'h0 : mgmt_mdc;
    assign int_mdio_o = mgmt_port_target_select ? 1'h0 : mgmt_mdio_o;
    assign int_mdio_oe = mgmt_port_target_select ? 1'h1 : mgmt_mdio_oe;
    // external mdio released and mdc low when internal is chosen
    assign ext_mdc = mgmt_port_target_select ? mgmt_mdc : 1'h0;
    assign ext_mdio_o = mgmt_port_target_select ? mgmt_mdio_o : 1'h0;
    assign ext_mdio_oe = mgmt_port_target_select ? mgmt_mdio_oe : 1'h0;

    // ==========================================================
    // strap capture: the pin passes the synchroniser before it is latched
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_mdio_sync_a <= 1'h0;
            ext_mdio_sync_b <= 1'h0;
            strap_wait <= 2'h0;
            strap_taken <= 1'h0;
            external_phy_strap_detect <= 1'h0;
        end
        else
        begin
            ext_mdio_sync_a <= ext_mdio_i;
            ext_mdio_sync_b <= ext_mdio_sync_a;
            if (strap_wait != 2'h2)
            begin
                strap_wait <= strap_wait + 2'h1;
            end
            else if (!strap_taken)
            begin
                // latch strap once after hard reset
                external_phy_strap_detect <= ext_mdio_sync_b;
                strap_taken <= 1'h1;
            end
        end
    end

    // ==========================================================
    // soft reset sequencer
    phy_clk_monitor rx_monitor
    (
        .pclk(pclk),
        .presetn(presetn),
        .sample_clk(int_rx_clk),
        .running(rx_clk_running)
    );

    phy_clk_monitor tx_monitor
    (
        .pclk(pclk),
        .presetn(presetn),
        .sample_clk(int_tx_clk),
        .running(tx_clk_running)
    );

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_reset_request_state <= S_IDLE;
            soft_reset_request <= 1'h0;
            soft_reset_timeout_flag <= 1'h0;
            timeout_count <= 12'h000;
            pulse_count <= 4'h0;
            mac_csr_reset <= 1'h0;
            system_command_status_reset <= 1'h0;
            soft_reset_request_done_event <= 1'h0;
            soft_reset_request_timeout_event <= 1'h0;
        end
        else
        begin
            soft_reset_request_done_event <= 1'h0;
            soft_reset_request_timeout_event <= 1'h0;
            case (soft_reset_request_state)
                S_IDLE:
                begin
                    if (soft_reset_request_write)
                    begin
                        soft_reset_request <= 1'h1;
                        timeout_count <= 12'h000;
                        soft_reset_request_state <= S_WAIT_CLK;
                    end
                end
                S_WAIT_CLK:
                begin
                    // phy clocks must be running before the reset proceeds
                    if (rx_clk_running & tx_clk_running)
                    begin
                        pulse_count <= 4'h0;
                        mac_csr_reset <= 1'h1;
                        system_command_status_reset <= 1'h1;
                        soft_reset_request_state <= S_PULSE;
                    end
                    else if (timeout_count == TIMEOUT_LIMIT)
                    begin
                        soft_reset_timeout_flag <= 1'h1;
                        soft_reset_request <= 1'h0;
                        soft_reset_request_timeout_event <= 1'h1;
                        soft_reset_request_state <= S_IDLE;
                    end
                    else
                    begin
                        timeout_count <= timeout_count + 12'h001;
                    end
                end
                S_PULSE:
                begin
                    // reset outputs held for a fixed pulse
                    if (pulse_count == `SOFT_RESET_REQUEST_PULSE_CYCLES - 4'h1)
                    begin
                        mac_csr_reset <= 1'h0;
                        system_command_status_reset <= 1'h0;
                        soft_reset_request <= 1'h0;
                        soft_reset_timeout_flag <= 1'h0;
                        soft_reset_request_done_event <= 1'h1;
                        soft_reset_request_state <= S_IDLE;
                    end
                    else
                    begin
                        pulse_count <= pulse_count + 4'h1;
                    end
                end
                default:
                begin
                    soft_reset_request_state <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // latched transmit and receive errors
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transmit_error_flag <= 1'h0;
            receive_error_flag <= 1'h0;
        end
        else if (soft_reset_request_state == S_PULSE)
        begin
            transmit_error_flag <= 1'h0;
            receive_error_flag <= 1'h0;
        end
        else
        begin
            transmit_error_flag <= transmit_error_flag | tx_error_event;
            receive_error_flag <= receive_error_flag | rx_error_event;
        end
    end

    // ==========================================================
    // interrupt status: set wins over a clear in the same cycle
    assign set_mask = {rx_error_event, tx_error_event, soft_reset_request_timeout_event, soft_reset_request_done_event};

    always @*
    begin
        next_int_status = (int_status & ~clr_mask) | set_mask;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_status <= 4'h0;
        else
            int_status <= next_int_status;
    end

    assign irq = |(int_status & int_enable);

endmodule
`default_nettype wire

// File: bench/phy_model.sv
// behavioural phy side: internal phy clocks, management answers and strap pull
`timescale 1ns/1ps
`default_nettype none
module phy_model
(
    // bench control
    input wire logic pclk,
    input wire logic clk_run,
    input wire logic strap,
    // management lines from the block
    input wire logic int_mdio_o,
    input wire logic int_mdio_oe,
    input wire logic ext_mdio_o,
    input wire logic ext_mdio_oe,
    // towards the block
    output logic int_rx_clk,
    output logic int_tx_clk,
    output logic int_mdio_i,
    output logic ext_mdio_i
);
    logic answer = 1'h0;
    // ==========
    // phy clocks
    initial
    begin
        int_rx_clk = 1'h0;
        int_tx_clk = 1'h0;
    end
    // clocks stand still while the phy is not operational
    always #20 if (clk_run) {int_rx_clk, int_tx_clk} = ~{int_rx_clk, int_tx_clk};
    // ==========
    // management lines
    // a released internal line has no pull, so it never repeats a stale bit
    always @(posedge pclk)
        answer <= ~answer;
    assign int_mdio_i = int_mdio_oe ? int_mdio_o : answer;
    // released external pin settles to its strap resistor
    assign ext_mdio_i = ext_mdio_oe ? ext_mdio_o : strap;
endmodule
`default_nettype wire

// File: bench/hw_config_assertions.sv
// port assertions for the hardware configuration block
`timescale 1ns/1ps
`default_nettype none
module hw_config_assertions
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // management routing
    input wire logic mgmt_mdc,
    input wire logic int_mdc,
    input wire logic int_mdio_o,
    input wire logic ext_mdc,
    input wire logic ext_mdio_oe,
    // clock routing and port enables
    input wire logic clk_route_internal,
    input wire logic clk_route_external,
    input wire logic clk_route_disabled,
    input wire logic external_mii_port_enable,
    input wire logic internal_phy_enable,
    // soft reset and error flags
    input wire logic mac_csr_reset,
    input wire logic system_command_status_reset,
    input wire logic transmit_error_flag,
    input wire logic receive_error_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========
    // management port
    mgmt_int_low_a: assert property (ext_mdc |-> !int_mdc && !int_mdio_o)
        else $error("internal management lines not held low");
    mgmt_ext_idle_a: assert property (int_mdc |-> !ext_mdc && !ext_mdio_oe)
        else $error("external management pins not idle");
    mgmt_one_target_a: assert property (mgmt_mdc |-> int_mdc ^ ext_mdc)
        else $error("management clock not on exactly one phy");
    // ==========
    // clock routing and port enables
    clk_route_onehot_a: assert property (
        $onehot({clk_route_internal, clk_route_external, clk_route_disabled}))
        else $error("clock route not one-hot");
    port_en_inverse_a: assert property (
        internal_phy_enable != $past(external_mii_port_enable))
        else $error("internal phy enable not inverse of port enable");
    // ==========
    // soft reset
    reset_outputs_pair_a: assert property (
        mac_csr_reset == system_command_status_reset)
        else $error("reset outputs differ");
    reset_pulse_len_a: assert property (
        $rose(mac_csr_reset) |-> mac_csr_reset[*4] ##1 !mac_csr_reset)
        else $error("soft reset pulse not four cycles");
    errors_cleared_a: assert property (
        $fell(mac_csr_reset) |-> !transmit_error_flag && !receive_error_flag)
        else $error("error flags survive soft reset");
    soft_reset_request_pulse_c: cover property ($rose(mac_csr_reset));
    ext_mgmt_c: cover property (ext_mdc);
    clk_off_c: cover property (clk_route_disabled);
endmodule
bind hw_config hw_config_assertions u_hw_config_assertions (.*);
`default_nettype wire

// File: bench/hw_config_tb.sv
// self-checking bench for the hardware configuration block
`timescale 1ns/1ps
`default_nettype none
`include "hardware_configuration_regs.vh"
module hw_config_tb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, pw;
    logic [3:0] pstrb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clk_run, strap;
    logic tx_error_event, rx_error_event, wake_event, int_rx_clk, int_tx_clk, irq;
    logic mgmt_mdc, mgmt_mdio_o, mgmt_mdio_oe, mgmt_mdio_i, int_mdc, int_mdio_o;
    logic int_mdio_oe, int_mdio_i, ext_mdc, ext_mdio_o, ext_mdio_oe, ext_mdio_i;
    logic clk_route_internal, clk_route_external, clk_route_disabled;
    logic external_mii_port_enable, internal_phy_enable, mac_csr_reset;
    logic system_command_status_reset, transmit_error_flag, receive_error_flag;
    logic [11:0] bad [3] = '{12'h0F0, `INT_CLR_OFFSET, `INT_STS_OFFSET};
    integer seed = 32'hDB3E;
    int num_errors = 0, total_checks = 0, cyc = 0, width = 0, pulses = 0, t0, w;

    hw_config u_hw_config (.*);
    phy_model u_phy_model (.pclk, .clk_run, .strap, .int_mdio_o, .int_mdio_oe, .ext_mdio_o,
        .ext_mdio_oe, .int_rx_clk, .int_tx_clk, .int_mdio_i, .ext_mdio_i);

    // ==========
    // clock, watchdog, counters
    initial
    begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    initial
    begin
        #100000;
        num_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        stop_test();
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (mac_csr_reset === 1'h1)
            width <= width + 1;
    end
    always @(posedge mac_csr_reset)
        pulses <= pulses + 1;

    // ==========
    // expectations and checks
    function automatic logic [31:0] hw(input logic [1:0] c, input logic m, e, t);
        return {25'h0, c, m, strap, e, t, 1'h0};
    endfunction
    function automatic logic [31:0] route_of(input logic [1:0] c);
        return (c == `CLKSEL_DISABLED) ? 32'h4 : ((c == `CLKSEL_EXTERNAL) ? 32'h2 : 32'h1);
    endfunction
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: level %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========
    // apb master; no tx or rx traffic runs while it writes
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1 && ++n < 100);
        rd = prdata;
        err = pslverr;
        chk_pin(n < 100, 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk_reg(rd, exp);
    endtask
    // a timed-out soft reset stays busy for 2500 cycles, so poll with a bound
    task automatic wait_idle();
        int n = 0;
        do
            apb(1'h0, `HWCFG_OFFSET, 32'h0);
        while (rd[0] !== 1'h0 && ++n < 2000);
    endtask

    // ==========
    // scenarios
    initial
    begin
        {psel, penable, pwrite, wake_event, tx_error_event, rx_error_event} = 6'h0;
        {mgmt_mdc, mgmt_mdio_o, mgmt_mdio_oe, presetn} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        clk_run = 1'h1;
        rd = $random(seed);
        strap = rd[0];
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h1, `HWCFG_OFFSET, 32'h74);
        rd_chk(`HWCFG_OFFSET, hw(2'h0, 1'h0, 1'h0, 1'h0));
        for (int i = 0; i < 8; i++)
        begin
            rd = $random(seed);
            pw = {rd[31:7], i[1:0], i[2], rd[3:1], 1'h0};
            apb(1'h1, `HWCFG_OFFSET, pw);
            rd_chk(`HWCFG_OFFSET, hw(pw[6:5], pw[4], pw[2], 1'h0));
            chk_reg({29'h0, clk_route_disabled, clk_route_external, clk_route_internal},
                route_of(pw[6:5]));
            chk_pin(external_mii_port_enable, pw[2]);
            chk_pin(internal_phy_enable, !pw[2]);
            mgmt_mdc <= 1'h1;
            mgmt_mdio_oe <= 1'h1;
            mgmt_mdio_o <= rd[3];
            @(posedge pclk);
            #1;
            chk_pin(ext_mdc, pw[4]);
            chk_pin(int_mdc, !pw[4]);
            chk_pin(ext_mdio_oe, pw[4]);
            @(posedge pclk);
            mgmt_mdc <= 1'h0;
            mgmt_mdio_oe <= 1'h0;
            repeat (3) @(posedge pclk);
            #1;
            chk_pin(mgmt_mdio_i, pw[4] ? strap : int_mdio_i);
        end
        for (int i = 0; i < 3; i++)
        begin
            apb(i == 2, bad[i], 32'hF);
            chk_pin(err, 1'h1);
        end
        wake_event <= 1'h1;
        @(posedge pclk);
        wake_event <= 1'h0;
        apb(1'h1, `HWCFG_OFFSET, 32'h0);
        rd_chk(`HWCFG_OFFSET, hw(pw[6:5], pw[4], pw[2], 1'h0));
        // stopped phy clocks: the request must time out
        clk_run <= 1'h0;
        repeat (60) @(posedge pclk);
        t0 = cyc;
        w = pulses;
        apb(1'h1, `HWCFG_OFFSET, pw | 32'h1);
        rd_chk(`HWCFG_OFFSET, hw(pw[6:5], pw[4], pw[2], 1'h0) | 32'h1);
        wait_idle();
        chk_reg(rd, hw(pw[6:5], pw[4], pw[2], 1'h1));
        chk_pin(cyc - t0 >= 2500 && cyc - t0 < 2600 && pulses == w, 1'h1);
        rd_chk(`INT_STS_OFFSET, 32'h2);
        apb(1'h1, `INT_EN_OFFSET, 32'h3);
        #1;
        chk_pin(irq, 1'h1);
        apb(1'h1, `INT_CLR_OFFSET, 32'h2);
        #1;
        chk_pin(irq, 1'h0);
        // pending errors, phy awake again, then a clean soft reset
        @(posedge pclk);
        tx_error_event <= 1'h1;
        rx_error_event <= 1'h1;
        clk_run <= 1'h1;
        @(posedge pclk);
        tx_error_event <= 1'h0;
        rx_error_event <= 1'h0;
        // phy clocks run well before the reset is asked for
        repeat (60) @(posedge pclk);
        #1;
        chk_pin(transmit_error_flag && receive_error_flag, 1'h1);
        w = pulses;
        width = 0;
        apb(1'h1, `HWCFG_OFFSET, pw | 32'h1);
        wait_idle();
        chk_reg(rd, hw(pw[6:5], pw[4], pw[2], 1'h0));
        chk_pin(pulses == w + 1 && width == 4, 1'h1);
        #1;
        chk_pin(irq, 1'h1);
        chk_pin(transmit_error_flag || receive_error_flag, 1'h0);
        apb(1'h1, `INT_EN_OFFSET, 32'h0);
        #1;
        chk_pin(irq, 1'h0);
        rd_chk(`INT_STS_OFFSET, 32'hD);
        apb(1'h1, `INT_CLR_OFFSET, 32'hF);
        rd_chk(`INT_STS_OFFSET, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
